// ==== hw/abcw_pkg.sv ====
package abcw_pkg;
  // register bus geometry: word w of bundle k at w*0x100 + 4*k
  localparam int          ADDR_W      = 11;
  localparam int          BUNDLES     = 64;
  localparam int          IDX_W       = 6;
  localparam logic [2:0]  BANK_RX_TAG = 3'h0;  // bundle_rx_tag_word bank
  localparam logic [2:0]  BANK_FORMAT = 3'h1;  // bundle_format_word bank
  localparam logic [2:0]  BANK_LAST   = 3'h4;  // fifth word bank of a record
  localparam int          BANK_LSB    = 8;
  localparam int          IDX_LSB     = 2;
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

  // field encodings of the format word
  localparam logic [1:0] PT_HDLC  = 2'h0;
  localparam logic [1:0] PT_AAL1  = 2'h1;
  localparam logic [1:0] PT_SATOP = 2'h3;
  localparam logic [1:0] DST_ETH  = 2'h1;
  localparam logic [1:0] DST_CPU  = 2'h2;
  localparam logic [1:0] DST_TDM  = 2'h3;
  localparam logic [4:0] SLOTS_UNSTRUCT = 5'h1f;

  // jitter depth scaling: bit periods per unit are 2**shift
  localparam int DEPTH_W        = 22;
  localparam int SHIFT_UNFRAMED = 10;  // 1024 bit periods
  localparam int SHIFT_HISPEED  = 12;  // 4096 bit periods

  typedef enum logic [1:0] {
    ABCW_IF_FRAMED,
    ABCW_IF_UNFRAMED,
    ABCW_IF_HISPEED
  } abcw_if_kind_t;

  // format word layout, msb first, fills 32 bits exactly
  typedef struct packed {
    logic [9:0] jb_depth;            // 31:22
    logic [1:0] payload_sel;         // 21:20
    logic       rtp_header_present;  // 19
    logic       cw_present;          // 18
    logic [1:0] tx_dest;             // 17:16
    logic [6:0] max_lost;            // 15:9
    logic [4:0] slot_count_minus_one;// 8:4
    logic       keep_sanity_fail;    // 3
    logic [1:0] hdr_type;            // 2:1
    logic       r_bit;               // 0
  } abcw_format_t;

  // routing and machine selections handed to packet logic
  typedef struct packed {
    logic to_eth;
    logic to_cpu;
    logic to_tdm;
  } abcw_route_t;

  typedef struct packed {
    logic hdlc;
    logic aal1;
    logic satop;
  } abcw_machine_t;
endpackage : abcw_pkg

// ==== hw/abcw_top.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
// What this block does
// - sixty-four independent bundle records, word0 at 4k
// - word0 stores full 32-bit receive bundle tag
// - jitter depth units depend on interface kind
// - payload selector picks HDLC, AAL1 or SAToP
// - RTP header added when flag set
// - control word presence flag, one means present
// - destination field routes to MAC, CPU, TDM
// - inserted lost packets never exceed programmed maximum
// - slot field holds timeslots minus one
// - sanity failures dropped unless keep bit set
// - R bit set in transmitted headers
// - five word banks at w*0x100 plus 4k; only words 0 and 1 are stored, 2..4 read zero
// - payload selector sits in format word 21:20
module abcw_top (
  input  wire logic                          i_clk,         // core clock
  input  wire logic                          i_rst_n,       // sync reset, low
  input  wire logic [abcw_pkg::ADDR_W-1:0]   i_addr,        // byte address
  input  wire logic [31:0]                   i_wdata,       // write data
  input  wire logic                          i_wr,          // write strobe
  input  wire logic                          i_rd,          // read strobe
  output logic      [31:0]                   o_rdata,       // read data, next cycle
  input  wire logic [abcw_pkg::IDX_W-1:0]    i_core_idx,    // bundle looked up
  input  wire abcw_pkg::abcw_if_kind_t       i_core_kind,   // interface kind
  input  wire logic [6:0]                    i_lost_count,  // lost packets seen
  input  wire logic                          i_sanity_fail, // packet failed sanity
  output logic      [31:0]                   o_rx_tag,      // receive bundle tag
  output abcw_pkg::abcw_format_t             o_cfg,         // format word fields
  output abcw_pkg::abcw_machine_t            o_machine,     // processing machine
  output abcw_pkg::abcw_route_t              o_route,       // transmit route
  output logic      [abcw_pkg::DEPTH_W-1:0]  o_jb_depth,    // scaled depth
  output logic      [6:0]                    o_fill_count,  // packets to insert
  output logic                               o_discard,     // drop this packet
  output logic                               o_cfg_bad      // reserved code used
);

  logic [2:0]                  bank;
  logic [abcw_pkg::IDX_W-1:0]  widx;
  logic [31:0]                 tag_mem [abcw_pkg::BUNDLES];
  logic [31:0]                 fmt_mem [abcw_pkg::BUNDLES];
  abcw_pkg::abcw_format_t      fmt_next;

  // address split into bank and bundle index
  assign bank = i_addr[abcw_pkg::BANK_LSB +: 3];
  assign widx = i_addr[abcw_pkg::IDX_LSB +: abcw_pkg::IDX_W];

  // one flop word pair per bundle; contents are cleared only so that
  // simulation is defined, software still programs each record first
  genvar k;
  generate
    for (k = 0; k < abcw_pkg::BUNDLES; k++) begin : g_rec
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          tag_mem[k] <= abcw_pkg::WORD_RESET;
          fmt_mem[k] <= abcw_pkg::WORD_RESET;
        end else if (i_wr && int'(widx) == k) begin
          if (bank == abcw_pkg::BANK_RX_TAG)
            tag_mem[k] <= i_wdata;
          if (bank == abcw_pkg::BANK_FORMAT)
            fmt_mem[k] <= i_wdata;
        end
      end
    end
  endgenerate

  // read port; words 2..4 and holes read as zero, writes there dropped
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd) begin
      unique case (bank)
        abcw_pkg::BANK_RX_TAG: o_rdata <= tag_mem[widx];
        abcw_pkg::BANK_FORMAT: o_rdata <= fmt_mem[widx];
        default:               o_rdata <= 32'h0000_0000;
      endcase
    end else
      o_rdata <= 32'h0000_0000;
  end

  // word layout matches the struct, so a cast decodes every field
  assign fmt_next = abcw_pkg::abcw_format_t'(fmt_mem[i_core_idx]);

  // core lookup, registered so packet logic sees stable fields
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_tag <= 32'h0000_0000;
      o_cfg    <= '0;
    end else begin
      o_rx_tag <= tag_mem[i_core_idx];
      o_cfg    <= fmt_next;
    end
  end

  // machine select; the reserved code selects nothing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_machine <= '0;
    else begin
      o_machine.hdlc  <= fmt_next.payload_sel == abcw_pkg::PT_HDLC;
      o_machine.aal1  <= fmt_next.payload_sel == abcw_pkg::PT_AAL1;
      o_machine.satop <= fmt_next.payload_sel == abcw_pkg::PT_SATOP;
    end
  end

  // routing; code 00 routes nowhere rather than guessing a target
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_route <= '0;
    else begin
      o_route.to_eth <= fmt_next.tx_dest == abcw_pkg::DST_ETH;
      o_route.to_cpu <= fmt_next.tx_dest == abcw_pkg::DST_CPU;
      o_route.to_tdm <= fmt_next.tx_dest == abcw_pkg::DST_TDM;
    end
  end

  // flag reserved payload or destination codes for the packet logic
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_cfg_bad <= 1'b0;
    else
      o_cfg_bad <= fmt_next.payload_sel == 2'h2 || fmt_next.tx_dest == 2'h0;
  end

  // depth scaled to bit periods; framed stays in half-ms units
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_jb_depth <= '0;
    else begin
      unique case (i_core_kind)
        abcw_pkg::ABCW_IF_UNFRAMED:
          o_jb_depth <= {2'h0, fmt_next.jb_depth, 10'h000};
        abcw_pkg::ABCW_IF_HISPEED:
          o_jb_depth <= {fmt_next.jb_depth, 12'h000};
        default:
          o_jb_depth <= {12'h000, fmt_next.jb_depth};
      endcase
    end
  end

  // fill limiter: clamp the substitute count to the programmed maximum
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_fill_count <= 7'h00;
    else if (i_lost_count > fmt_next.max_lost)
      o_fill_count <= fmt_next.max_lost;
    else
      o_fill_count <= i_lost_count;
  end

  // sanity policy: clear keep bit means the failing packet is dropped
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      o_discard <= 1'b0;
    else
      o_discard <= i_sanity_fail && !fmt_next.keep_sanity_fail;
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_unmapped_zero: assert property (
    i_rd && bank > abcw_pkg::BANK_FORMAT |=> o_rdata == 32'h0000_0000)
    else $error("unmapped bank read not zero");

  a_tag_readback: assert property (
    (i_wr && bank == abcw_pkg::BANK_RX_TAG)
      ##1 (i_rd && !i_wr && i_addr == $past(i_addr))
    |=> o_rdata == $past(i_wdata, 2))
    else $error("tag word readback mismatch");

  a_rbit_lookup: assert property (
    (i_wr && bank == abcw_pkg::BANK_FORMAT)
      ##1 (!i_wr && i_core_idx == $past(widx))
    |=> o_cfg.r_bit == $past(i_wdata[0], 2) && o_machine.aal1 ==
        ($past(i_wdata[21:20], 2) == abcw_pkg::PT_AAL1))
    else $error("format lookup does not follow write");

  a_fill_limit: assert property (
    o_fill_count <= o_cfg.max_lost &&
    (o_fill_count == o_cfg.max_lost || o_fill_count == $past(i_lost_count)))
    else $error("fill count exceeds limit");

  a_sanity_drop: assert property (
    o_discard == ($past(i_sanity_fail) && !o_cfg.keep_sanity_fail))
    else $error("sanity discard policy wrong");

  a_route_decode: assert property (
    $onehot0(o_route) && ((o_route == '0) == (o_cfg.tx_dest == 2'h0)))
    else $error("route decode wrong");

  a_machine_decode: assert property (
    $onehot0(o_machine) && (o_machine.satop == (o_cfg.payload_sel == 2'h3)))
    else $error("machine decode wrong");

  a_depth_scale: assert property (
    $past(i_core_kind) == abcw_pkg::ABCW_IF_HISPEED
    |-> o_jb_depth == {o_cfg.jb_depth, 12'h000})
    else $error("high speed depth scale wrong");

  // each write lands in its own word and nowhere else; a stray bank
  // decode would silently corrupt a live bundle record
  a_tag_store: assert property (
    i_wr && bank == abcw_pkg::BANK_RX_TAG |=> tag_mem[$past(widx)] == $past(i_wdata))
    else $error("tag word write lost");

  a_fmt_store: assert property (
    i_wr && bank == abcw_pkg::BANK_FORMAT |=> fmt_mem[$past(widx)] == $past(i_wdata))
    else $error("format word write lost");

  a_fmt_untouched: assert property (
    i_wr && bank == abcw_pkg::BANK_RX_TAG
    |=> fmt_mem[$past(widx)] == $past(fmt_mem[widx]))
    else $error("tag write disturbed format word");

  a_tag_untouched: assert property (
    i_wr && bank == abcw_pkg::BANK_FORMAT
    |=> tag_mem[$past(widx)] == $past(tag_mem[widx]))
    else $error("format write disturbed tag word");

  // banks two to four are not stored, so such writes must vanish
  a_unmapped_write: assert property (
    i_wr && bank > abcw_pkg::BANK_FORMAT
    |=> tag_mem[$past(widx)] == $past(tag_mem[widx]) &&
        fmt_mem[$past(widx)] == $past(fmt_mem[widx]))
    else $error("unmapped bank write changed storage");

  // read data stand for one cycle only; idle cycles must read zero
  // so that a bus mux further up can simply or the slaves together
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");

  a_rdata_tag: assert property (
    i_rd && bank == abcw_pkg::BANK_RX_TAG |=> o_rdata == $past(tag_mem[widx]))
    else $error("tag word read wrong");

  a_rdata_fmt: assert property (
    i_rd && bank == abcw_pkg::BANK_FORMAT |=> o_rdata == $past(fmt_mem[widx]))
    else $error("format word read wrong");

  // lookup fields against fixed bit positions of the stored word,
  // independent of the struct, so a layout slip shows up here
  a_tag_lookup: assert property (
    1'b1 |=> o_rx_tag == $past(tag_mem[i_core_idx]))
    else $error("looked up tag wrong");

  a_depth_field: assert property (
    1'b1 |=> o_cfg.jb_depth == $past(fmt_mem[i_core_idx][31:22]))
    else $error("depth field misplaced");

  a_rtp_flag: assert property (
    1'b1 |=> o_cfg.rtp_header_present == $past(fmt_mem[i_core_idx][19]))
    else $error("header flag misplaced");

  a_cw_flag: assert property (
    1'b1 |=> o_cfg.cw_present == $past(fmt_mem[i_core_idx][18]))
    else $error("control word flag misplaced");

  a_lost_field: assert property (
    1'b1 |=> o_cfg.max_lost == $past(fmt_mem[i_core_idx][15:9]))
    else $error("lost packet limit misplaced");

  a_slot_field: assert property (
    1'b1 |=> o_cfg.slot_count_minus_one == $past(fmt_mem[i_core_idx][8:4]))
    else $error("slot count misplaced");

  a_keep_field: assert property (
    1'b1 |=> o_cfg.keep_sanity_fail == $past(fmt_mem[i_core_idx][3]))
    else $error("sanity policy bit misplaced");

  a_hdr_field: assert property (
    1'b1 |=> o_cfg.hdr_type == $past(fmt_mem[i_core_idx][2:1]))
    else $error("header type misplaced");

  a_reserved_flag: assert property (
    1'b1 |=> o_cfg_bad == ($past(fmt_mem[i_core_idx][21:20]) == 2'h2 ||
                           $past(fmt_mem[i_core_idx][17:16]) == 2'h0))
    else $error("reserved code flag wrong");

  // depth units per interface kind; framed stays in half-ms steps,
  // unframed and high speed count bit periods of the line clock
  a_depth_framed: assert property (
    $past(i_core_kind) == abcw_pkg::ABCW_IF_FRAMED
    |-> o_jb_depth == {12'h000, o_cfg.jb_depth})
    else $error("framed depth scale wrong");

  a_depth_unframed: assert property (
    $past(i_core_kind) == abcw_pkg::ABCW_IF_UNFRAMED
    |-> o_jb_depth == {12'h000, o_cfg.jb_depth} << abcw_pkg::SHIFT_UNFRAMED)
    else $error("unframed depth scale wrong");

  // scenarios worth seeing at least once in simulation
  c_fill_clamped: cover property (i_lost_count > fmt_next.max_lost);
  c_tag_readback: cover property (i_wr ##1 i_rd ##1 o_rdata != 32'h0);
  c_discard_seen: cover property (o_discard);
  c_hispeed_depth: cover property (
    $past(i_core_kind) == abcw_pkg::ABCW_IF_HISPEED && o_jb_depth[abcw_pkg::DEPTH_W-1]);
  c_reserved_code: cover property (o_cfg_bad && o_cfg.tx_dest != 2'h0);

endmodule : abcw_top

// ==== test/aal1_bundle_config_words_tb.sv ====
`timescale 1ns/1ns
module aal1_bundle_config_words_tb;
  logic                           i_clk, i_rst_n, i_wr, i_rd, i_sanity_fail;
  logic [abcw_pkg::ADDR_W-1:0]    i_addr;
  logic [31:0]                    i_wdata, o_rdata, o_rx_tag;
  logic [abcw_pkg::IDX_W-1:0]     i_core_idx;
  abcw_pkg::abcw_if_kind_t        i_core_kind;
  logic [6:0]                     i_lost_count, o_fill_count;
  abcw_pkg::abcw_format_t         o_cfg, fw;
  abcw_pkg::abcw_machine_t        o_machine;
  abcw_pkg::abcw_route_t          o_route;
  logic [abcw_pkg::DEPTH_W-1:0]   o_jb_depth;
  logic                           o_discard, o_cfg_bad;
  int                             fails, tests_run, cycles;

  abcw_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_idx(i_core_idx),
    .i_core_kind(i_core_kind), .i_lost_count(i_lost_count), .i_sanity_fail(i_sanity_fail),
    .o_rx_tag(o_rx_tag), .o_cfg(o_cfg), .o_machine(o_machine), .o_route(o_route),
    .o_jb_depth(o_jb_depth), .o_fill_count(o_fill_count), .o_discard(o_discard),
    .o_cfg_bad(o_cfg_bad));

  // free-running core clock, 8 ns
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle strobes, data held with the strobe
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd

  // lookup answers on the edge after the inputs are driven
  task automatic look(input logic [5:0] k, input abcw_pkg::abcw_if_kind_t kd,
                      input logic [6:0] lost, input logic sf);
    @(posedge i_clk);
    i_core_idx    <= k;
    i_core_kind   <= kd;
    i_lost_count  <= lost;
    i_sanity_fail <= sf;
    @(posedge i_clk);
    #1;
  endtask : look

  // edge bundles, both stored banks, unstored bank 2 refused
  task automatic t_regs;
    wr(11'h000, 32'hdead_beef);
    wr(11'h0fc, 32'h1234_5678);
    wr(11'h1fc, 32'h8765_4321);
    wr(11'h200, 32'hffff_ffff);
    rd(11'h000, 32'hdead_beef);
    rd(11'h0fc, 32'h1234_5678);
    rd(11'h1fc, 32'h8765_4321);
    rd(11'h100, 32'h0000_0000);
    rd(11'h200, 32'h0000_0000);
    look(6'h3f, abcw_pkg::ABCW_IF_FRAMED, 7'h0, 1'b0);
    chk(o_rx_tag, 32'h1234_5678);
  endtask : t_regs

  // write then read of the same word on the very next edge, then idle
  task automatic t_b2b;
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= 11'h014;
    i_wdata <= 32'hcafe_f00d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, 32'hcafe_f00d);
    @(posedge i_clk);
    #1 chk(o_rdata, 32'h0000_0000);
  endtask : t_b2b

  // every selector and destination code, reserved ones flagged
  task automatic t_decode;
    for (int p = 0; p < 4; p++) begin
      for (int d = 0; d < 4; d++) begin
        fw = '0;
        fw.payload_sel = 2'(p);
        fw.tx_dest = 2'(d);
        wr(11'h114, fw);
        look(6'h05, abcw_pkg::ABCW_IF_FRAMED, 7'h0, 1'b0);
        chk(o_machine, (p == 0) ? 3'h4 : (p == 1) ? 3'h2 : (p == 3) ? 3'h1 : 3'h0);
        chk(o_route, (d == 0) ? 3'h0 : 3'h1 << (3 - d));
        chk(o_cfg_bad, 32'((p == 2) || (d == 0)));
      end
    end
  endtask : t_decode

  // field placement, depth units, fill clamp, sanity policy
  task automatic t_fields;
    fw = '{10'h2fc, 2'h1, 1'b1, 1'b1, 2'h1, 7'h05, 5'h1f, 1'b0, 2'h2, 1'b1};
    wr(11'h124, fw);
    look(6'h09, abcw_pkg::ABCW_IF_FRAMED, 7'h09, 1'b1);
    chk(o_cfg, fw);
    chk(o_jb_depth, 32'h2fc);
    chk(o_fill_count, 32'h05);
    chk(o_discard, 32'h1);
    look(6'h09, abcw_pkg::ABCW_IF_UNFRAMED, 7'h03, 1'b0);
    chk(o_jb_depth, 32'h2fc << 10);
    chk(o_fill_count, 32'h03);
    chk(o_discard, 32'h0);
    look(6'h09, abcw_pkg::ABCW_IF_HISPEED, 7'h05, 1'b1);
    chk(o_jb_depth, 32'h2fc << 12);
    chk(o_fill_count, 32'h05);
    for (int h = 0; h < 4; h++) begin
      fw = '{10'h001, 2'h3, 1'b0, 1'b0, 2'h2, 7'h7f, 5'h00, 1'b1, 2'(h), 1'b0};
      wr(11'h124, fw);
      look(6'h09, abcw_pkg::ABCW_IF_FRAMED, 7'h7f, 1'b1);
      chk(o_cfg, fw);
      chk({o_cfg.rtp_header_present, o_cfg.cw_present, o_cfg.r_bit}, 32'h0);
      chk(o_discard, 32'h0);
    end
  endtask : t_fields

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // hang guard, far above the roughly 120 cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  // reset, then the scenarios in turn
  initial begin
    {i_rst_n, i_wr, i_rd, i_sanity_fail, i_addr, i_wdata, i_core_idx, i_lost_count} = '0;
    i_core_kind = abcw_pkg::ABCW_IF_FRAMED;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_b2b();
    t_decode();
    t_fields();
    close_out();
  end
endmodule : aal1_bundle_config_words_tb
